// ---- rtl/adcx_config.sv ----
// extended adc configuration bank with accumulator, comparator,
// result counter, fast temperature override and ground switch
// assumes both adc result ports are synchronous to pclk
// Functional notes
// RULE_01 - config bit 7 set connects the switched ground pin through the 20k resistor.
// RULE_02 - software keeps reserved bits 6 and 5 unchanged on every write.
// RULE_03 - accumulator bit 4 low clears the accumulator, high sums each current result.
// RULE_04 - software keeps the accumulator off for two current ready events before re-enabling.
// RULE_05 - comparator bit 3 high flags any current result whose magnitude reaches the threshold.
// RULE_06 - software writes reserved bit 2 as zero.
// RULE_07 - fast bit 1 forces the internal temperature sensor regardless of the input select.
// RULE_08 - the fast override selects only the internal temperature input and nothing else.
// RULE_09 - software clears the fast bit once the fast conversion is done.
// RULE_10 - counter bit 0 raises the current ready event only when the count hits the limit.
// RULE_11 - in count mode the v/t channel keeps converting and only its last result is kept.
// RULE_12 - on reaching the limit the count returns to zero and counts on.
// RULE_13 - threshold uses bits 15:0 in unipolar mode and bits 14:0 in two's complement.
// RULE_14 - a write to the current channel control clears the result count.
// RULE_15 - the accumulator clears when disabled or when the current channel is reconfigured.
//
// Decided for this implementation: the APB register port and the address map.
module adcx_config (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // adc results
   input wire adcx_pkg::adcx_result_s i_result,
   input wire adcx_pkg::adcx_result_s vt_result,
   // analog controls
   output logic switched_ground_pin_en,
   output logic [1:0] vt_input_select,
   output logic twos_mode,
   // interrupt
   output logic irq
);
   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   logic [7:0] adc_extended_config;
   logic [15:0] result_count_limit;
   logic [15:0] result_count_value;
   logic [15:0] current_threshold;
   logic [31:0] acc;
   logic [15:0] idat;
   logic [15:0] vdat;
   logic [2:0] adc_status_reg;
   logic [2:0] irq_mask;
   logic [7:0] icon;
   logic [7:0] vt_channel_control;

   // ---------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------
   wire wr = psel && penable && pwrite;
   wire hit_cfg = paddr == adcx_pkg::OFF_CFG;
   wire hit_idat = paddr == adcx_pkg::OFF_IDAT;
   wire hit_vdat = paddr == adcx_pkg::OFF_VDAT;
   wire hit_rcl = paddr == adcx_pkg::OFF_RCL;
   wire hit_rcv = paddr == adcx_pkg::OFF_RCV;
   wire hit_th = paddr == adcx_pkg::OFF_TH;
   wire hit_acc = paddr == adcx_pkg::OFF_ACC;
   wire hit_sta = paddr == adcx_pkg::OFF_STA;
   wire hit_msk = paddr == adcx_pkg::OFF_MSK;
   wire hit_icon = paddr == adcx_pkg::OFF_ICON;
   wire hit_vcon = paddr == adcx_pkg::OFF_VCON;
   wire mapped = hit_cfg | hit_idat | hit_vdat | hit_rcl | hit_rcv | hit_th
      | hit_acc | hit_sta | hit_msk | hit_icon | hit_vcon;
   wire wr_cfg = wr && hit_cfg;
   wire wr_icon = wr && hit_icon;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ---------------------------------------------------------
   // control bits
   // ---------------------------------------------------------
   wire acc_en = adc_extended_config[adcx_pkg::CFG_ACC];
   wire cmp_en = adc_extended_config[adcx_pkg::CFG_CMP];
   wire fast_en = adc_extended_config[adcx_pkg::CFG_FAST];
   wire cnt_en = adc_extended_config[adcx_pkg::CFG_CNT];

   assign switched_ground_pin_en = adc_extended_config[adcx_pkg::CFG_GND]; // RULE_01
   assign twos_mode = icon[adcx_pkg::ICON_TWOS];
   // only the select field is overridden, nothing else of the channel
   assign vt_input_select = fast_en ? adcx_pkg::SEL_INT_TEMP
      : vt_channel_control[7:6]; // RULE_07 RULE_08

   // ---------------------------------------------------------
   // comparator and counter
   // ---------------------------------------------------------
   function automatic logic [15:0] magnitude(input logic [15:0] d, input logic twos);
      magnitude = (twos && d[15]) ? 16'(~d + 16'h0001) : d;
   endfunction : magnitude

   // in two's complement mode the top threshold bit is ignored
   wire [15:0] th_eff = twos_mode ? {1'b0, current_threshold[14:0]}
      : current_threshold; // RULE_13
   wire cmp_hit = cmp_en && i_result.valid
      && magnitude(i_result.data, twos_mode) >= th_eff; // RULE_05
   wire [15:0] cnt_inc = 16'(result_count_value + 16'h0001);
   wire cnt_match = cnt_en && i_result.valid && cnt_inc == result_count_limit;
   wire irdy_evt = i_result.valid && (!cnt_en || cnt_match); // RULE_10
   // v/t ready is deferred to the counter event in count mode
   wire vrdy_evt = cnt_en ? cnt_match : vt_result.valid; // RULE_11
   wire [2:0] evt = {cmp_hit, vrdy_evt, irdy_evt};
   wire [31:0] i_ext = twos_mode ? {{16{i_result.data[15]}}, i_result.data}
      : {16'h0000, i_result.data};

   // ---------------------------------------------------------
   // register writes
   // ---------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_extended_config <= adcx_pkg::RST_CFG;
         result_count_limit <= adcx_pkg::RST_RCL;
         current_threshold <= adcx_pkg::RST_TH;
         irq_mask <= 3'h0;
         icon <= 8'h00;
         vt_channel_control <= 8'h00;
      end else if (wr) begin
         if (hit_cfg) adc_extended_config <= pwdata[7:0];
         if (hit_rcl) result_count_limit <= pwdata[15:0];
         if (hit_th) current_threshold <= pwdata[15:0];
         if (hit_msk) irq_mask <= pwdata[2:0];
         if (hit_icon) icon <= pwdata[7:0];
         if (hit_vcon) vt_channel_control <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_count_value <= 16'h0000;
      end else if (wr_icon) begin
         result_count_value <= 16'h0000; // RULE_14
      end else if (cnt_en && i_result.valid) begin
         result_count_value <= cnt_match ? 16'h0000 : cnt_inc; // RULE_12
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= 32'h0000_0000;
      end else if (!acc_en || wr_icon) begin
         acc <= 32'h0000_0000; // RULE_03 RULE_15
      end else if (i_result.valid) begin
         acc <= acc + i_ext; // RULE_03
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idat <= 16'h0000;
         vdat <= 16'h0000;
      end else begin
         if (i_result.valid) idat <= i_result.data;
         // later results overwrite earlier ones
         if (vt_result.valid) vdat <= vt_result.data; // RULE_11
      end
   end

   // ---------------------------------------------------------
   // status and interrupt
   // ---------------------------------------------------------
   // set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_status_reg <= 3'h0;
      end else begin
         adc_status_reg <= (adc_status_reg & ~((wr && hit_sta) ? pwdata[2:0] : 3'h0)) | evt;
      end
   end

   assign irq = |(adc_status_reg & irq_mask);

   // ---------------------------------------------------------
   // read mux
   // ---------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (1'b1)
            hit_cfg: prdata <= {24'h000000, adc_extended_config};
            hit_idat: prdata <= {16'h0000, idat};
            hit_vdat: prdata <= {16'h0000, vdat};
            hit_rcl: prdata <= {16'h0000, result_count_limit};
            hit_rcv: prdata <= {16'h0000, result_count_value};
            hit_th: prdata <= {16'h0000, current_threshold};
            hit_acc: prdata <= acc;
            hit_sta: prdata <= {29'h0000000, adc_status_reg};
            hit_msk: prdata <= {29'h0000000, irq_mask};
            hit_icon: prdata <= {24'h000000, icon};
            hit_vcon: prdata <= {24'h000000, vt_channel_control};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_gnd_follows_cfg: assert property (wr_cfg |=> switched_ground_pin_en == $past(pwdata[7])) // RULE_01
      else $error("ground switch does not follow config");
   a_acc_cleared: assert property (!acc_en |=> acc == 32'h0000_0000) // RULE_03
      else $error("accumulator not cleared while disabled");
   a_acc_sums: assert property (acc_en && !wr_icon && i_result.valid && !wr_cfg
      |=> acc == 32'($past(acc) + $past(i_ext))) // RULE_03
      else $error("accumulator did not add result");
   a_cmp_flag: assert property (cmp_en && i_result.valid
      && magnitude(i_result.data, twos_mode) >= th_eff |=> adc_status_reg[2]) // RULE_05
      else $error("comparator event missed");
   a_cmp_off: assert property (!cmp_en |-> !cmp_hit) // RULE_05
      else $error("comparator fired while disabled");
   a_fast_select: assert property (fast_en |-> vt_input_select == 2'h2) // RULE_07
      else $error("fast mode did not force temperature sensor");
   a_cnt_gate: assert property (cnt_en && i_result.valid && cnt_inc != result_count_limit
      |-> !irdy_evt) // RULE_10
      else $error("current ready raised before limit");
   a_cnt_wrap: assert property (cnt_match && !wr_icon |=> result_count_value == 16'h0000) // RULE_12
      else $error("count did not wrap to zero");
   a_cnt_reconfig: assert property (wr_icon |=> result_count_value == 16'h0000
      && acc == 32'h0000_0000) // RULE_14 RULE_15
      else $error("reconfigure did not clear count and accumulator");
   a_th_twos: assert property (twos_mode |-> th_eff[15] == 1'b0) // RULE_13
      else $error("threshold top bit used in two's complement");
   a_vt_defer: assert property (cnt_en && vt_result.valid && !cnt_match |-> !vrdy_evt) // RULE_11
      else $error("v/t ready raised in count mode");
   a_vt_plain: assert property (!cnt_en && vt_result.valid
      |-> vrdy_evt) // RULE_11
      else $error("v/t ready missing outside count mode");
   a_vdat_last: assert property (vt_result.valid
      |=> vdat == $past(vt_result.data)) // RULE_11
      else $error("v/t data not overwritten by latest result");
   a_fast_off: assert property (!fast_en
      |-> vt_input_select == vt_channel_control[7:6]) // RULE_08
      else $error("select overridden without fast mode");
   a_cmp_below: assert property (cmp_en && i_result.valid
      && magnitude(i_result.data, twos_mode) < th_eff |-> !cmp_hit) // RULE_05
      else $error("comparator fired below threshold");
   a_cnt_step: assert property (cnt_en && i_result.valid && !cnt_match && !wr_icon
      |=> result_count_value == $past(cnt_inc)) // RULE_10
      else $error("count did not step on current result");
   a_cnt_hold: assert property (!cnt_en && !wr_icon
      |=> $stable(result_count_value)) // RULE_10
      else $error("count moved while counter disabled");
   a_irdy_plain: assert property (!cnt_en && i_result.valid
      |-> irdy_evt) // RULE_10
      else $error("current ready missing outside count mode");
   a_irdy_sets: assert property (irdy_evt
      |=> adc_status_reg[adcx_pkg::ST_IRDY]) // RULE_10
      else $error("current ready event lost against clear");
   a_twos_follows: assert property (wr_icon
      |=> twos_mode == $past(pwdata[0])) // RULE_13
      else $error("two's mode does not follow current control");

   // ---------------------------------------------------------
   // bus and status checks
   // ---------------------------------------------------------
   // w1c must clear a flag that no event sets again
   a_sta_clear: assert property (wr && hit_sta && pwdata[0] && !irdy_evt
      |=> !adc_status_reg[adcx_pkg::ST_IRDY])
      else $error("status bit not cleared by write one");
   a_irq_masked: assert property ((adc_status_reg & irq_mask) == 3'h0
      |-> !irq)
      else $error("interrupt raised with nothing unmasked");
   a_idat_capture: assert property (i_result.valid
      |=> idat == $past(i_result.data))
      else $error("current data not captured");
   a_ready_fixed: assert property (pready == 1'b1)
      else $error("wait state inserted");
   a_err_unmapped: assert property (psel && penable && !mapped
      |-> pslverr)
      else $error("unmapped access not flagged");
   a_read_cfg: assert property (psel && !penable && !pwrite && hit_cfg
      |=> prdata == {24'h000000, $past(adc_extended_config)})
      else $error("config read data wrong");
   a_th_write: assert property (wr && hit_th
      |=> current_threshold == $past(pwdata[15:0]))
      else $error("threshold write lost");
   a_rcl_write: assert property (wr && hit_rcl
      |=> result_count_limit == $past(pwdata[15:0]))
      else $error("count limit write lost");


   c_cnt_match: cover property (cnt_match);
   c_cmp_irq: cover property (cmp_hit ##1 irq);
   c_fast_temp: cover property (wr_cfg ##1 fast_en);
   c_acc_run: cover property (acc_en && i_result.valid ##1 acc != 32'h0000_0000);
   c_cnt_reconfig: cover property (wr_icon && result_count_value != 16'h0000);
endmodule : adcx_config

// ---- rtl/adcx_pkg.sv ----
// package for the adc extended function configuration block
// assumes an apb slave on pclk with a byte address of 8 bits
package adcx_pkg;
   // ---------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------
   localparam logic [7:0] OFF_CFG = 8'h1C;
   localparam logic [7:0] OFF_IDAT = 8'h20;
   localparam logic [7:0] OFF_VDAT = 8'h24;
   localparam logic [7:0] OFF_RCL = 8'h48;
   localparam logic [7:0] OFF_RCV = 8'h4C;
   localparam logic [7:0] OFF_TH = 8'h50;
   localparam logic [7:0] OFF_ACC = 8'h5C;
   localparam logic [7:0] OFF_STA = 8'h60;
   localparam logic [7:0] OFF_MSK = 8'h64;
   localparam logic [7:0] OFF_ICON = 8'h68;
   localparam logic [7:0] OFF_VCON = 8'h6C;
   // ---------------------------------------------------------
   // reset values
   // ---------------------------------------------------------
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [15:0] RST_RCL = 16'h0001;
   localparam logic [15:0] RST_TH = 16'h0000;
   // ---------------------------------------------------------
   // field positions
   // ---------------------------------------------------------
   localparam int CFG_GND = 7;
   localparam int CFG_ACC = 4;
   localparam int CFG_CMP = 3;
   localparam int CFG_FAST = 1;
   localparam int CFG_CNT = 0;
   localparam int ST_IRDY = 0;
   localparam int ST_VRDY = 1;
   localparam int ST_CMP = 2;
   localparam int ICON_TWOS = 0;
   localparam logic [1:0] SEL_INT_TEMP = 2'h2;
   // ---------------------------------------------------------
   // types
   // ---------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } adcx_result_s;
endpackage : adcx_pkg

// ---- tb/adcx_config_tb.sv ----
// self-checking bench for the adc extended configuration bank
// assumes a zero wait state apb slave and adc result pulses on pclk
module adcx_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gnd_en, twos, irq, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [1:0] vsel;
   adcx_pkg::adcx_result_s i_res, v_res;
   int errors, compares;
   adcx_config i_adcx_config (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_result(i_res), .vt_result(v_res),
      .switched_ground_pin_en(gnd_en), .vt_input_select(vsel), .twos_mode(twos), .irq(irq));
   // ---------------------------------------------------------
   // tasks
   // ---------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // entered and left just after a rising edge, with one idle cycle after
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0000_0000);
   endtask : rd
   task res(input logic cur, input logic [15:0] d);
      if (cur) i_res <= '{1'b1, d};
      else v_res <= '{1'b1, d};
      @(posedge pclk);
      i_res.valid <= 1'b0; v_res.valid <= 1'b0;
      @(posedge pclk);
   endtask : res
   task give_verdict;
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // ---------------------------------------------------------
   // clock, reset and watchdog
   // ---------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #200us;
      errors++;
      give_verdict();
   end
   // ---------------------------------------------------------
   // tests
   // ---------------------------------------------------------
   initial begin
      errors = 0; compares = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000; i_res = '0; v_res = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(adcx_pkg::OFF_CFG); chk(rdata, 32'h0000_0000);
      rd(adcx_pkg::OFF_RCL); chk(rdata, 32'h0000_0001);
      rd(8'h04); chk({rdata[30:0], rerr}, 32'h0000_0001);
      // reserved bits kept by read-modify-write, ground follows bit 7
      wr(adcx_pkg::OFF_CFG, 32'h0000_00E0); chk(gnd_en, 1'b1);
      rd(adcx_pkg::OFF_CFG); wr(adcx_pkg::OFF_CFG, rdata & 32'h0000_0060);
      rd(adcx_pkg::OFF_CFG); chk({rdata, gnd_en}, {32'h0000_0060, 1'b0});
      // accumulator sums while enabled, clears on reconfigure and disable
      wr(adcx_pkg::OFF_CFG, 32'h0000_0010); res(1'b1, 16'h0003); res(1'b1, 16'h0005);
      rd(adcx_pkg::OFF_ACC); chk(rdata, 32'h0000_0008);
      wr(adcx_pkg::OFF_ICON, 32'h0000_0001); rd(adcx_pkg::OFF_ACC); chk(rdata, 32'h0);
      res(1'b1, 16'hFFFE); res(1'b1, 16'h0005); chk(twos, 1'b1);
      rd(adcx_pkg::OFF_ACC); chk(rdata, 32'h0000_0003);
      wr(adcx_pkg::OFF_CFG, 32'h0000_0000); rd(adcx_pkg::OFF_ACC); chk(rdata, 32'h0);
      // accumulator kept off for two current results before re-enabling
      res(1'b1, 16'h0009); res(1'b1, 16'h0009);
      wr(adcx_pkg::OFF_CFG, 32'h0000_0010);
      rd(adcx_pkg::OFF_ACC); chk(rdata, 32'h0);
      res(1'b1, 16'h0009); rd(adcx_pkg::OFF_ACC); chk(rdata, 32'h0000_0009);
      // comparator: off, two's edge with bit 15 ignored, unipolar edge
      wr(adcx_pkg::OFF_STA, 32'h0000_0007); wr(adcx_pkg::OFF_TH, 32'h0000_8100);
      res(1'b1, 16'hFF00); rd(adcx_pkg::OFF_STA); chk(rdata[2], 1'b0);
      wr(adcx_pkg::OFF_CFG, 32'h0000_0008); wr(adcx_pkg::OFF_MSK, 32'h0000_0004);
      res(1'b1, 16'hFF01); rd(adcx_pkg::OFF_STA); chk({rdata[2], irq}, 2'b00);
      res(1'b1, 16'hFF00); rd(adcx_pkg::OFF_STA); chk({rdata[2], irq}, 2'b11);
      wr(adcx_pkg::OFF_MSK, 32'h0); chk(irq, 1'b0);
      wr(adcx_pkg::OFF_MSK, 32'h0000_0004); wr(adcx_pkg::OFF_STA, 32'h0000_0004); chk(irq, 1'b0);
      wr(adcx_pkg::OFF_ICON, 32'h0); wr(adcx_pkg::OFF_TH, 32'h0000_8000);
      res(1'b1, 16'h7FFF); rd(adcx_pkg::OFF_STA); chk(rdata[2], 1'b0);
      res(1'b1, 16'h8000); rd(adcx_pkg::OFF_STA); chk({rdata[2], irq}, 2'b11);
      // fast temperature overrides the select only while set
      wr(adcx_pkg::OFF_VCON, 32'h0000_0040); chk(vsel, 2'h1);
      wr(adcx_pkg::OFF_CFG, 32'h0000_0002); chk(vsel, adcx_pkg::SEL_INT_TEMP);
      wr(adcx_pkg::OFF_CFG, 32'h0000_0000); chk(vsel, 2'h1);
      // result count mode with a limit of three
      wr(adcx_pkg::OFF_RCL, 32'h0000_0003); wr(adcx_pkg::OFF_CFG, 32'h0000_0001);
      res(1'b1, 16'h0001); wr(adcx_pkg::OFF_ICON, 32'h0);
      rd(adcx_pkg::OFF_RCV); chk(rdata, 32'h0);
      wr(adcx_pkg::OFF_STA, 32'h0000_0007);
      res(1'b1, 16'h0001); res(1'b0, 16'h1111); res(1'b1, 16'h0001); res(1'b0, 16'h2222);
      rd(adcx_pkg::OFF_RCV); chk(rdata, 32'h0000_0002);
      rd(adcx_pkg::OFF_STA); chk(rdata[1:0], 2'b00);
      res(1'b1, 16'h0001); rd(adcx_pkg::OFF_STA); chk(rdata[1:0], 2'b11);
      rd(adcx_pkg::OFF_RCV); chk(rdata, 32'h0);
      rd(adcx_pkg::OFF_VDAT); chk(rdata, 32'h0000_2222);
      give_verdict();
   end
endmodule : adcx_config_tb
